/* psc_board_model.sv */
// board pulls and strap resistors on the shared receive pins
`timescale 1ns/1ps
module psc_board_model (
	input  wire [8:0] pin_out,
	input  wire [8:0] pin_oe,
	input  wire [8:0] ext,
	input  wire [8:0] ext_en,
	output wire [8:0] pin
);
	// order irq, rx_er, rx_dv, crs, rx_clk, rxd[3:0]; weak pulls lose to any driver
	localparam [8:0] PULL = 9'h109;
	assign pin = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext) | (~ext_en & PULL)));
endmodule

/* psc_defs.vh */
// constants for the strap configuration latch
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH
`define PSC_ADDR_CFG        12'h000
`define PSC_ADDR_STAT       12'h004
`define PSC_ADDR_BMCR       12'h008
`define PSC_ADDR_RXCTL      12'h00c
`define PSC_ADDR_TXSTAT     12'h010
`define PSC_BMCR_ANEG_BIT   12
`define PSC_MODE_NORM_NOX   3'h0
`define PSC_MODE_NORM_X     3'h2
`define PSC_MODE_B2B_X      3'h6
`define PSC_PULL_PHYAD      3'h1
`define PSC_PULL_MODE       3'h0
`define PSC_PULL_ANEG       1'h1
`define PSC_PULL_NAND       1'h1
`define PSC_PULL_EMI        1'h0
`define PSC_PULL_RXD        4'h9
`define PSC_PULL_MISC       5'h02
`define PSC_RST_TX          5'h00
`define PSC_BMCR_RST        32'h00000000
`endif

/* psc_strap_checker.sv */
// assertions on the strap latch pins and decoded outputs
`timescale 1ns/1ps
module psc_strap_checker (
	input wire       pclk,
	input wire       presetn,
	input wire [3:0] rxd_out,
	input wire [3:0] rxd_oe,
	input wire       rx_dv_out,
	input wire       rx_dv_oe,
	input wire       rx_clk_out,
	input wire       irq_oe,
	input wire [4:0] mgmt_phy_address,
	input wire [2:0] op_mode,
	input wire       auto_mdix_en,
	input wire       back_to_back
);
	reg [3:0] cnt;
	// edges since release, saturating so late checks never wrap back
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_fresh;
		$rose(presetn);
	endsequence
	property fresh_p;
		s_fresh |-> mgmt_phy_address == 5'h01 ##9 rxd_oe == 4'hf && rx_dv_oe;
	endproperty
	strap_fresh_a: assert property (fresh_p) else $error("bad pins after release");
	pins_quiet_a: assert property (cnt < 4'h4 |-> rxd_oe == 4'h0 && !rx_dv_oe && !irq_oe)
		else $error("pin driven in strap window");
	addr_top_a: assert property (mgmt_phy_address[4:3] == 2'b00) else $error("addr top set");
	cfg_hold_a: assert property (cnt > 4'h9 |-> $stable(mgmt_phy_address) && $stable(op_mode))
		else $error("configuration changed");
	mode_plain_a: assert property (op_mode == 3'h0 |-> !auto_mdix_en && !back_to_back)
		else $error("mode 000 decode");
	mode_cross_a: assert property (op_mode == 3'h2 |-> auto_mdix_en && !back_to_back)
		else $error("mode 010 decode");
	mode_b2b_a: assert property (op_mode == 3'h6 |-> auto_mdix_en && back_to_back)
		else $error("mode 110 decode");
	rx_idle_a: assert property (cnt > 4'h9 && rx_dv_oe && !rx_dv_out |-> rxd_out == 4'h0)
		else $error("rxd without valid");
	rx_clock_a: assert property (cnt > 4'h9 |-> rx_clk_out != $past(rx_clk_out))
		else $error("receive clock stalled");
endmodule
bind psc_strap_latch psc_strap_checker i_psc_strap_checker (.pclk, .presetn, .rxd_out, .rxd_oe,
	.rx_dv_out, .rx_dv_oe, .rx_clk_out, .irq_oe, .mgmt_phy_address, .op_mode, .auto_mdix_en,
	.back_to_back);

/* psc_strap_latch.v */
// strap configuration latch with mii receive pin drive and apb registers
// Contract
// - sample straps once at reset release
// - pins are inputs in reset, outputs after, except irq which stays an input
// - address low bits from straps, top zero
// - unstrapped address defaults to 00001
// - mode codes 000, 010, 110 select modes
// - inverted aneg_disable_strap strap into control bit 12
// - low interrupt strap enables nand tree
// - high rx error strap disables filter
// - rx data clocked, valid with data valid
`timescale 1ns/1ps
`include "psc_defs.vh"
module psc_strap_latch (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [3:0]  rxd_in,
	output reg  [3:0]  rxd_out,
	output reg  [3:0]  rxd_oe,
	input  wire        rx_dv_in,
	output reg         rx_dv_out,
	output reg         rx_dv_oe,
	input  wire        rx_er_in,
	output reg         rx_er_out,
	output reg         rx_er_oe,
	input  wire        rx_clk_in,
	output reg         rx_clk_out,
	output reg         rx_clk_oe,
	input  wire        crs_in,
	output reg         crs_out,
	output reg         crs_oe,
	input  wire        irq_in,
	output reg         irq_out,
	output reg         irq_oe,
	input  wire        tx_en,
	input  wire [3:0]  txd,
	output reg  [4:0]  mgmt_phy_address,
	output reg  [2:0]  op_mode,
	output reg         auto_mdix_en,
	output reg         back_to_back,
	output reg         aneg_enable,
	output reg         nand_tree_en,
	output reg         emission_filter_en,
	output reg         mode_reserved
);
	localparam ST_RESET = 3'b001;
	localparam ST_LOAD  = 3'b010;
	localparam ST_RUN   = 3'b100;

	// pins from outside the clock domain; pull defaults hold during sync
	wire [3:0] rxd_s;
	wire [4:0] misc_s;
	wire [4:0] tx_s;
	psc_sync2 #(.W(4), .INIT(`PSC_PULL_RXD)) u_sync_rxd (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (rxd_in),
		.q       (rxd_s)
	);
	// order rx_dv, crs, rx_clk, irq, rx_er; only the interrupt pin pulls up
	psc_sync2 #(.W(5), .INIT(`PSC_PULL_MISC)) u_sync_misc (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({rx_dv_in, crs_in, rx_clk_in, irq_in, rx_er_in}),
		.q       (misc_s)
	);
	psc_sync2 #(.W(5), .INIT(`PSC_RST_TX)) u_sync_tx (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({tx_en, txd}),
		.q       (tx_s)
	);

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [1:0]  settle;
	reg  [31:0] bmcr;
	reg         rx_tx_loop;
	reg  [3:0]  rx_data;
	reg         rx_valid;
	reg         rx_err;
	reg  [3:0]  tx_last;
	reg  [7:0]  tx_nibbles;
	wire [8:0]  strap_q;
	wire        strap_done;
	// strap word: rxd straps, mode code, rx error, interrupt pin
	wire [8:0]  strap_d = {rxd_s, misc_s[4], misc_s[3], misc_s[2], misc_s[0], misc_s[1]};

	// settle gives the synchroniser time to carry real pin levels
	always @* begin
		next_state = state;
		case (state)
			ST_RESET: begin
				if (settle == 2'h3)
					next_state = ST_LOAD;
			end
			ST_LOAD:  next_state = ST_RUN;
			ST_RUN:   next_state = ST_RUN;
			default:  next_state = ST_RESET;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state  <= ST_RESET;
			settle <= 2'h0;
		end else begin
			state <= next_state;
			if (state == ST_RESET)
				settle <= settle + 2'h1;
		end
	end

	// one load per reset release; done flag blocks reloads
	psc_strap_reg u_strap (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (state == ST_LOAD),
		.d       (strap_d),
		.q       (strap_q),
		.done    (strap_done)
	);

	function [2:0] mode_norm;
		input [2:0] code;
		begin
			mode_norm = code;
		end
	endfunction

	// decoded configuration; driven from the latched word only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mgmt_phy_address   <= {2'h0, `PSC_PULL_PHYAD};
			op_mode            <= `PSC_PULL_MODE;
			auto_mdix_en       <= 1'b0;
			back_to_back       <= 1'b0;
			aneg_enable        <= ~`PSC_PULL_ANEG;
			nand_tree_en       <= ~`PSC_PULL_NAND;
			emission_filter_en <= ~`PSC_PULL_EMI;
			mode_reserved      <= 1'b0;
		end else if (strap_done) begin
			// rxd3 is bit0, rxd2 bit1, rxd1 bit2; top bits forced zero
			mgmt_phy_address   <= {2'h0, strap_q[6], strap_q[7], strap_q[8]};
			op_mode            <= mode_norm(strap_q[4:2]);
			auto_mdix_en       <= (strap_q[4:2] == `PSC_MODE_NORM_X) ||
			                      (strap_q[4:2] == `PSC_MODE_B2B_X);
			back_to_back       <= (strap_q[4:2] == `PSC_MODE_B2B_X);
			// flags a code the board must not present
			mode_reserved      <= (strap_q[4:2] != `PSC_MODE_NORM_NOX) &&
			                      (strap_q[4:2] != `PSC_MODE_NORM_X) &&
			                      (strap_q[4:2] != `PSC_MODE_B2B_X);
			aneg_enable        <= ~strap_q[5];
			nand_tree_en       <= ~strap_q[0];
			emission_filter_en <= ~strap_q[1];
		end
	end

	// control register; bit 12 takes the inverted strap at load
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bmcr       <= `PSC_BMCR_RST;
			rx_tx_loop <= 1'b0;
			rx_data    <= 4'h0;
			rx_valid   <= 1'b0;
			rx_err     <= 1'b0;
		end else if (state == ST_LOAD) begin
			bmcr[`PSC_BMCR_ANEG_BIT] <= ~strap_d[5];
		end else if (psel && penable && pwrite) begin
			if (paddr == `PSC_ADDR_BMCR)
				bmcr <= pwdata;
			else if (paddr == `PSC_ADDR_RXCTL) begin
				rx_data    <= pwdata[3:0];
				rx_valid   <= pwdata[4];
				rx_err     <= pwdata[5];
				rx_tx_loop <= pwdata[8];
			end
		end
	end

	// tx nibbles counted only while tx enable is high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_last    <= 4'h0;
			tx_nibbles <= 8'h00;
		end else if (tx_s[4]) begin
			tx_last    <= tx_s[3:0];
			tx_nibbles <= tx_nibbles + 8'h01;
		end
	end

	// pins are released during reset and straps, driven after except irq, which stays released
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_oe     <= 4'h0;
			rx_dv_oe   <= 1'b0;
			rx_er_oe   <= 1'b0;
			rx_clk_oe  <= 1'b0;
			crs_oe     <= 1'b0;
			irq_oe     <= 1'b0;
			rxd_out    <= 4'h0;
			rx_dv_out  <= 1'b0;
			rx_er_out  <= 1'b0;
			rx_clk_out <= 1'b0;
			crs_out    <= 1'b0;
			irq_out    <= 1'b0;
		end else if (state == ST_RUN) begin
			rxd_oe     <= 4'hf;
			rx_dv_oe   <= 1'b1;
			rx_er_oe   <= 1'b1;
			rx_clk_oe  <= 1'b1;
			crs_oe     <= 1'b1;
			irq_oe     <= 1'b0; // open drain, released in every state
			// receive clock toggles; data change with its falling edge
			rx_clk_out <= ~rx_clk_out;
			if (rx_clk_out) begin
				rx_dv_out <= rx_tx_loop ? tx_s[4] : rx_valid;
				rxd_out   <= (rx_tx_loop ? tx_s[4] : rx_valid) ?
				             (rx_tx_loop ? tx_s[3:0] : rx_data) : 4'h0;
				rx_er_out <= rx_err;
				crs_out   <= rx_tx_loop ? tx_s[4] : rx_valid;
			end
		end
	end

	// apb: zero wait, unmapped addresses answer with an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (psel && !penable) begin
				if (paddr == `PSC_ADDR_CFG)
					prdata <= {18'h0, mode_reserved, emission_filter_en, nand_tree_en,
					           aneg_enable, back_to_back, auto_mdix_en, op_mode, mgmt_phy_address};
				else if (paddr == `PSC_ADDR_STAT)
					prdata <= {19'h0, strap_done, tx_last, tx_nibbles};
				else if (paddr == `PSC_ADDR_BMCR)
					prdata <= bmcr;
				else if (paddr == `PSC_ADDR_RXCTL)
					prdata <= {23'h0, rx_tx_loop, 2'h0, rx_err, rx_valid, rx_data};
				else if (paddr == `PSC_ADDR_TXSTAT)
					prdata <= {27'h0, tx_s};
				else
					pslverr <= 1'b1;
			end
		end
	end
endmodule

/* psc_strap_latch_test.sv */
// bench: strap cases, apb access, receive drive, transmit count
`timescale 1ns/1ps
module psc_strap_latch_test;
	reg         pclk = 1'b0, presetn, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg         tx_en = 1'b0, err;
	reg  [3:0]  txd = 4'h0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0, rd;
	reg  [8:0]  ext = 9'h000, ext_en = 9'h000;
	reg  [8:0]  sv [0:3] = '{9'h000, 9'h0ea, 9'h125, 9'h10e};
	reg  [31:0] ev [0:3] = '{32'h1001, 32'h0fc5, 32'h1142, 32'h1407};
	integer     fails = 0, compares = 0, i, n;
	wire [31:0] prdata, cfg_out;
	wire [8:0]  pin, pout, poe;
	wire [4:0]  mgmt_phy_address;
	wire [3:0]  rxd_out, rxd_oe;
	wire [2:0]  op_mode;
	wire        pready, pslverr, rx_dv_out, rx_dv_oe, rx_er_out, rx_er_oe, rx_clk_out, rx_clk_oe;
	wire        crs_out, crs_oe, irq_out, irq_oe, auto_mdix_en, back_to_back, aneg_enable;
	wire        nand_tree_en, emission_filter_en, mode_reserved;
	assign pout = {irq_out, rx_er_out, rx_dv_out, crs_out, rx_clk_out, rxd_out};
	assign poe = {irq_oe, rx_er_oe, rx_dv_oe, crs_oe, rx_clk_oe, rxd_oe};
	assign cfg_out = {18'h0, mode_reserved, emission_filter_en, nand_tree_en, aneg_enable,
		back_to_back, auto_mdix_en, op_mode, mgmt_phy_address};
	psc_board_model i_psc_board_model (.pin_out(pout), .pin_oe(poe), .ext, .ext_en, .pin);
	psc_strap_latch i_psc_strap_latch (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rxd_in(pin[3:0]), .rxd_out, .rxd_oe,
		.rx_dv_in(pin[6]), .rx_dv_out, .rx_dv_oe, .rx_er_in(pin[7]), .rx_er_out, .rx_er_oe,
		.rx_clk_in(pin[4]), .rx_clk_out, .rx_clk_oe, .crs_in(pin[5]), .crs_out, .crs_oe,
		.irq_in(pin[8]), .irq_out, .irq_oe, .tx_en, .txd, .mgmt_phy_address, .op_mode,
		.auto_mdix_en, .back_to_back, .aneg_enable, .nand_tree_en, .emission_filter_en,
		.mode_reserved);
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task complete_run;
		begin
			$display("counts: %0d compares, %0d fails", compares, fails);
			if (fails == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 50);
			rd = prdata;
			err = pslverr;
			if (pready !== 1'b1) begin
				fails = fails + 1;
				complete_run;
			end
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// straps only count until the load a few edges after reset release, so they are set inside reset
	task strap_reset(input [8:0] e, input [8:0] v);
		begin
			@(posedge pclk);
			presetn <= 1'b0;
			ext_en <= e;
			ext <= v;
			repeat (4) @(posedge pclk);
			cmp({23'h0, poe}, 32'h0);
			presetn <= 1'b1;
			repeat (12) @(posedge pclk);
		end
	endtask
	// s holds carrier sense, receive error and data valid, in that order
	task wait_dv(input [2:0] s, input [3:0] d);
		begin
			n = 0;
			while (rx_dv_out !== s[0] && n < 40) begin
				@(posedge pclk);
				n = n + 1;
			end
			cmp({25'h0, crs_out, rx_er_out, rx_dv_out, rxd_out}, {25'h0, s, d});
			if (n == 40)
				complete_run;
		end
	endtask
	initial forever #25 pclk = ~pclk;
	initial begin
		// a real edge at time zero, so the asynchronous reset is seen
		presetn <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			strap_reset(i == 0 ? 9'h000 : 9'h1ff, sv[i]);
			cmp(cfg_out, ev[i]);
			cmp({23'h0, poe}, 32'h0ff);
			apb(1'b0, 12'h000, 32'h0);
			cmp(rd, ev[i]);
			apb(1'b0, 12'h008, 32'h0);
			cmp(rd, {19'h0, ev[i][10], 12'h0});
			ext <= ~sv[i];
			repeat (8) @(posedge pclk);
			cmp(cfg_out, ev[i]);
			$display("strap case %0d done", i);
		end
		apb(1'b0, 12'h020, 32'h0);
		cmp(rd, 32'h0);
		cmp({31'h0, err}, 32'h1);
		apb(1'b1, 12'h00c, 32'h3a);
		wait_dv(3'h7, 4'ha);
		apb(1'b1, 12'h00c, 32'h05);
		wait_dv(3'h0, 4'h0);
		apb(1'b0, 12'h00c, 32'h0);
		cmp(rd, 32'h5);
		$display("receive test done");
		txd <= 4'h9;
		repeat (4) @(posedge pclk);
		tx_en <= 1'b1;
		txd <= 4'h3;
		repeat (3) @(posedge pclk);
		tx_en <= 1'b0;
		txd <= 4'hc;
		repeat (4) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		cmp(rd, 32'h1303);
		$display("transmit test done");
		apb(1'b1, 12'h00c, 32'h100);
		tx_en <= 1'b1;
		txd <= 4'h6;
		wait_dv(3'h5, 4'h6);
		tx_en <= 1'b0;
		wait_dv(3'h0, 4'h0);
		$display("loopback test done");
		complete_run;
	end
endmodule

/* psc_strap_reg.v */
// holding register for the latched strap word, loaded once per reset
`timescale 1ns/1ps
module psc_strap_reg (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        load,
	input  wire [8:0]  d,
	output reg  [8:0]  q,
	output reg         done
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q    <= 9'h000;
			done <= 1'b0;
		end else if (load && !done) begin
			q    <= d;
			done <= 1'b1;
		end
	end
endmodule

/* psc_sync2.v */
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module psc_sync2 #(
	parameter W    = 1,
	parameter INIT = 0
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= INIT[W-1:0];
			q    <= INIT[W-1:0];
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
